// ===== core/serial_program_command_unit.sv
`timescale 1ns/1ps
// Behaviour
// - Flash page reads all-ones while programming
// - Whole flash page committed in one write
// - EEPROM byte reads all-ones while programming
// - Four-byte instructions; enable is AC 53
// - AC then 100x erases flash and EEPROM
// - Program memory read returns selected byte
// - Page load: six-bit address, low first
// - Opcode 4C writes page buffer to flash
// - Opcode A0 reads EEPROM byte
// - Opcode C0 writes EEPROM byte
// - Lock bits write AC 111x, read 58 00
// - Fuse writes AC A0 and AC A8
// - Fuse reads 50 00 and 58 08
// - Opcode 38 reads selected calibration byte
// - Sample on rising, drive on falling edge
// - Echo enable byte two during byte three
// - EEPROM write auto-erases its location
module serial_program_command_unit #(
  parameter int FLASH_WAIT_CYCLES = serial_prog_pkg::FLASH_PAGE_WAIT_CYCLES,
  parameter int EEPROM_WAIT_CYCLES = serial_prog_pkg::EEPROM_BYTE_WAIT_CYCLES,
  parameter int ERASE_CYCLES = serial_prog_pkg::ERASE_WAIT_CYCLES,
  parameter int FUSE_CYCLES = serial_prog_pkg::FUSE_WAIT_CYCLES,
  parameter logic [7:0] FUSE_LOW_INIT = 8'hff,
  parameter logic [7:0] FUSE_HIGH_INIT = 8'hff
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic [31:0] cal_bytes,
  output logic miso,
  output logic miso_oe,
  output logic prog_enabled,
  output logic busy,
  output logic [serial_prog_pkg::LOCK_W-1:0] lock_bits,
  output logic [7:0] fuse_low,
  output logic [7:0] fuse_high
);
  import serial_prog_pkg::*;

  logic sck_s;
  logic mosi_s;
  logic rst_pin_s;
  logic sck_d;
  logic [31:0] sr;
  logic [5:0] bitcnt;
  logic byte2_done;
  logic byte3_done;
  logic word_done;
  logic [7:0] tx;
  busy_kind_t busy_kind;
  logic [BUSY_W-1:0] busy_cnt;
  logic [PAGE_NUM_W-1:0] busy_page;
  logic [EEPROM_ADDR_W-1:0] busy_ee_addr;
  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0] eeprom_mem [EEPROM_BYTES];
  logic [15:0] page_buf [PAGE_WORDS];

  // A polled location shows all-ones while its programming runs
  function automatic logic [7:0] poll_mask(input logic hidden, input logic [7:0] data);
    return hidden ? POLL_VALUE : data;
  endfunction

  // Three-stage filter also drops one-clock glitches on the programmer's pins
  sync3 #(.W(3), .RESET_VAL(3'h4)) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .din({prog_reset_n, sck, mosi}),
    .dout({rst_pin_s, sck_s, mosi_s})
  );

  // Reset pin high means normal operation: the link is held idle
  wire link_idle = rst_pin_s;
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;
  wire [5:0] next_bitcnt = bitcnt + 6'h1;

  // Bytes one to three, seen when byte three has just arrived
  wire [7:0] r1 = sr[23:16];
  wire [7:0] r2 = sr[15:8];
  wire [7:0] r3 = sr[7:0];
  // Whole instruction, seen when byte four has just arrived
  wire [7:0] w1 = sr[31:24];
  wire [7:0] w2 = sr[23:16];
  wire [7:0] w3 = sr[15:8];
  wire [7:0] w4 = sr[7:0];

  // Read decode; bits marked don't-care are simply not compared
  wire is_flash_rd = r1[7:4] == OP_FLASH_READ_TOP && r1[2:0] == OP_SEL_LOW;
  wire is_ee_rd = r1 == OP_EE_READ;
  wire is_lock_rd = r1 == OP_LOCK_READ && r2 == BYTE_ZERO;
  wire is_fuse_lo_rd = r1 == OP_FUSE_READ && r2 == BYTE_ZERO;
  wire is_fuse_hi_rd = r1 == OP_LOCK_READ && r2 == FUSE_HI_RD_B2;
  wire is_cal_rd = r1 == OP_CAL_READ;

  wire [FLASH_ADDR_W-1:0] rd_flash_addr = {r2[5:0], r3};
  wire [15:0] rd_word = flash_mem[rd_flash_addr];
  wire [7:0] rd_flash_byte = r1[3] ? rd_word[15:8] : rd_word[7:0];
  // Any word of the page in flight is a valid polling target
  wire flash_hidden = busy_kind == BUSY_FLASH
    && rd_flash_addr[FLASH_ADDR_W-1:PAGE_WORD_W] == busy_page;
  wire [EEPROM_ADDR_W-1:0] rd_ee_addr = {r2[1:0], r3};
  wire ee_hidden = busy_kind == BUSY_EEPROM && rd_ee_addr == busy_ee_addr;
  wire [7:0] rd_cal = cal_bytes[{r3[1:0], 3'h0} +: 8];

  wire [7:0] read_byte = !prog_enabled ? BYTE_ZERO
    : is_flash_rd ? poll_mask(flash_hidden, rd_flash_byte)
    : is_ee_rd ? poll_mask(ee_hidden, eeprom_mem[rd_ee_addr])
    : is_lock_rd ? {LOCK_PAD, lock_bits}
    : is_fuse_lo_rd ? fuse_low
    : is_fuse_hi_rd ? fuse_high
    : is_cal_rd ? rd_cal
    : BYTE_ZERO;

  // Execute decode on the complete instruction
  wire is_prefix = w1 == OP_PREFIX;
  wire do_enable = word_done && is_prefix && w2 == OP_ENABLE_B2;
  // Writes are refused while a self-timed operation is running
  wire wr_ok = word_done && prog_enabled && !busy;
  wire do_erase = wr_ok && is_prefix && w2[7:5] == ERASE_B2_TOP;
  wire do_lock_wr = wr_ok && is_prefix && w2[7:5] == LOCK_B2_TOP;
  wire do_fuse_lo_wr = wr_ok && is_prefix && w2 == FUSE_LO_WR_B2;
  wire do_fuse_hi_wr = wr_ok && is_prefix && w2 == FUSE_HI_WR_B2;
  wire do_load = word_done && prog_enabled
    && w1[7:4] == OP_PAGE_LOAD_TOP && w1[2:0] == OP_SEL_LOW;
  wire do_page_wr = wr_ok && w1 == OP_PAGE_WRITE;
  wire do_ee_wr = wr_ok && w1 == OP_EE_WRITE;
  wire do_fuse_any = do_lock_wr | do_fuse_lo_wr | do_fuse_hi_wr;
  wire start_busy = do_erase | do_page_wr | do_ee_wr | do_fuse_any;

  wire [PAGE_NUM_W-1:0] wr_page = {w2[5:0], w3[7:6]};
  wire [PAGE_WORD_W-1:0] load_idx = w3[PAGE_WORD_W-1:0];
  wire [EEPROM_ADDR_W-1:0] wr_ee_addr = {w2[1:0], w3};

  // Busy lengths match the programmer's blind waits, so polling and waiting agree
  wire [BUSY_W-1:0] start_cycles = do_erase ? BUSY_W'(ERASE_CYCLES)
    : do_page_wr ? BUSY_W'(FLASH_WAIT_CYCLES)
    : do_ee_wr ? BUSY_W'(EEPROM_WAIT_CYCLES)
    : BUSY_W'(FUSE_CYCLES);
  wire busy_kind_t start_kind = do_erase ? BUSY_ERASE
    : do_page_wr ? BUSY_FLASH
    : do_ee_wr ? BUSY_EEPROM
    : BUSY_FUSE;
  wire busy_last = busy_cnt == BUSY_W'(1);

  // Serial input: bits taken on rising SCK, MSB first
  always_ff @(posedge clk) begin
    if (srst || link_idle) begin
      sr <= '0;
      bitcnt <= '0;
      byte2_done <= 1'b0;
      byte3_done <= 1'b0;
      word_done <= 1'b0;
    end else begin
      byte2_done <= sck_rise && next_bitcnt == BYTE2_END;
      byte3_done <= sck_rise && next_bitcnt == BYTE3_END;
      word_done <= sck_rise && next_bitcnt == BITS_PER_WORD;
      if (sck_rise) begin
        sr <= {sr[30:0], mosi_s};
        bitcnt <= (next_bitcnt == BITS_PER_WORD) ? 6'h0 : next_bitcnt;
      end
    end
  end

  // Edge tracker runs outside sessions too, so a session opened with SCK
  // already high sees no false rise
  always_ff @(posedge clk) begin
    if (srst) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
    end
  end

  // Output enable follows the session, not the frame
  always_ff @(posedge clk) begin
    if (srst || link_idle) begin
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= 1'b1;
    end
  end

  // Serial output: next bit presented on each falling SCK
  always_ff @(posedge clk) begin
    if (srst || link_idle) begin
      tx <= '0;
      miso <= 1'b0;
    end else begin
      if (byte2_done) begin
        tx <= sr[7:0];
      end else if (byte3_done) begin
        tx <= read_byte;
      end else if (sck_fall) begin
        miso <= tx[7];
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  // Enable survives only while the reset pin stays low
  always_ff @(posedge clk) begin
    if (srst || link_idle) begin
      prog_enabled <= 1'b0;
    end else if (do_enable) begin
      prog_enabled <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lock_bits <= LOCK_RESET;
      fuse_low <= FUSE_LOW_INIT;
      fuse_high <= FUSE_HIGH_INIT;
    end else begin
      if (do_erase) begin
        lock_bits <= LOCK_RESET;
      end else if (do_lock_wr) begin
        lock_bits <= w4[LOCK_W-1:0];
      end
      if (do_fuse_lo_wr) begin
        fuse_low <= w4;
      end
      if (do_fuse_hi_wr) begin
        fuse_high <= w4;
      end
    end
  end

  // Self-timed operation tracker; what it holds decides which reads are masked
  always_ff @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
      busy_kind <= BUSY_NONE;
      busy_cnt <= '0;
    end else if (start_busy) begin
      busy <= 1'b1;
      busy_kind <= start_kind;
      busy_cnt <= start_cycles;
    end else if (busy) begin
      if (busy_last) begin
        busy <= 1'b0;
        busy_kind <= BUSY_NONE;
      end
      busy_cnt <= busy_cnt - BUSY_W'(1);
    end
  end

  // Target of the write in flight; only read while busy_kind names it
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_page <= '0;
      busy_ee_addr <= '0;
    end else if (start_busy) begin
      busy_page <= wr_page;
      busy_ee_addr <= wr_ee_addr;
    end
  end

  // Page buffer keeps each half of a word separately, so low then high both land
  always_ff @(posedge clk) begin
    if (do_load) begin
      if (w1[3]) begin
        page_buf[load_idx][15:8] <= w4;
      end else begin
        page_buf[load_idx][7:0] <= w4;
      end
    end
  end

  // Non-volatile arrays: no reset
  always_ff @(posedge clk) begin
    if (do_erase) begin
      for (int i = 0; i < FLASH_WORDS; i++) begin
        flash_mem[i] <= ERASED_WORD;
      end
    end else if (do_page_wr) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        flash_mem[{wr_page, PAGE_WORD_W'(i)}] <= page_buf[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (do_erase) begin
      for (int i = 0; i < EEPROM_BYTES; i++) begin
        eeprom_mem[i] <= POLL_VALUE;
      end
    end else if (do_ee_wr) begin
      // Overwrite acts as erase-then-program, so no prior chip erase is needed
      eeprom_mem[wr_ee_addr] <= w4;
    end
  end

  // Unmatched instructions drive none of the do_ strobes and change nothing
endmodule // serial_program_command_unit

// ===== core/serial_prog_pkg.sv
package serial_prog_pkg;

  // Core clock
  localparam real CLK_MHZ = 125.0;

  // Self-timed programming waits, in milliseconds
  localparam real FLASH_PAGE_WAIT_TIME_MS = 4.5;
  localparam real EEPROM_BYTE_WAIT_TIME_MS = 9.0;
  localparam real ERASE_WAIT_TIME_MS = 9.0;
  localparam real FUSE_WAIT_TIME_MS = 4.5;

  // Busy must not outlast the programmer's blind wait, so round down
  function automatic int ms_to_cycles(input real ms);
    int c;
    c = int'($floor(ms * CLK_MHZ * 1000.0));
    return (c < 1) ? 1 : c;
  endfunction

  localparam int FLASH_PAGE_WAIT_CYCLES = ms_to_cycles(FLASH_PAGE_WAIT_TIME_MS);
  localparam int EEPROM_BYTE_WAIT_CYCLES = ms_to_cycles(EEPROM_BYTE_WAIT_TIME_MS);
  localparam int ERASE_WAIT_CYCLES = ms_to_cycles(ERASE_WAIT_TIME_MS);
  localparam int FUSE_WAIT_CYCLES = ms_to_cycles(FUSE_WAIT_TIME_MS);
  localparam int BUSY_W = 21;

  // Array geometry fixed by the instruction fields
  localparam int FLASH_ADDR_W = 14;
  localparam int PAGE_WORD_W = 6;
  localparam int PAGE_NUM_W = 8;
  localparam int EEPROM_ADDR_W = 10;
  localparam int FLASH_WORDS = 16384;
  localparam int PAGE_WORDS = 64;
  localparam int EEPROM_BYTES = 1024;
  localparam int LOCK_W = 6;

  // Instruction codes
  localparam logic [7:0] OP_PREFIX = 8'hac;
  localparam logic [7:0] OP_ENABLE_B2 = 8'h53;
  localparam logic [2:0] ERASE_B2_TOP = 3'h4;
  localparam logic [2:0] LOCK_B2_TOP = 3'h7;
  localparam logic [7:0] FUSE_LO_WR_B2 = 8'ha0;
  localparam logic [7:0] FUSE_HI_WR_B2 = 8'ha8;
  localparam logic [3:0] OP_FLASH_READ_TOP = 4'h2;
  localparam logic [3:0] OP_PAGE_LOAD_TOP = 4'h4;
  localparam logic [2:0] OP_SEL_LOW = 3'h0;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h4c;
  localparam logic [7:0] OP_EE_READ = 8'ha0;
  localparam logic [7:0] OP_EE_WRITE = 8'hc0;
  localparam logic [7:0] OP_LOCK_READ = 8'h58;
  localparam logic [7:0] OP_FUSE_READ = 8'h50;
  localparam logic [7:0] FUSE_HI_RD_B2 = 8'h08;
  localparam logic [7:0] OP_CAL_READ = 8'h38;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Values
  localparam logic [7:0] POLL_VALUE = 8'hff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [LOCK_W-1:0] LOCK_RESET = 6'h3f;
  localparam logic [1:0] LOCK_PAD = 2'h3;

  // Serial framing
  localparam logic [5:0] BITS_PER_WORD = 6'h20;
  localparam logic [5:0] BYTE2_END = 6'h10;
  localparam logic [5:0] BYTE3_END = 6'h18;

  typedef enum logic [2:0] {
    BUSY_NONE,
    BUSY_FLASH,
    BUSY_EEPROM,
    BUSY_ERASE,
    BUSY_FUSE
  } busy_kind_t;

endpackage

// ===== core/sync3.sv
`timescale 1ns/1ps
// Three-stage synchroniser; an output bit follows once stages two and three agree
module sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= (s2 & s3) | (dout & (s2 ^ s3));
    end
  end
endmodule // sync3

// ===== tb/prog_link_model.sv
`timescale 1ns/1ps
module prog_link_model (
  input wire logic clk,
  input wire logic miso,
  output logic sck,
  output logic mosi
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
  end
  // Whole instruction, MSB first; miso is read just before each rise
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      @(negedge clk);
      sck = 1'b0;
      mosi = cmd[i];
      repeat (10) @(negedge clk);
      rx[i] = miso;
      sck = 1'b1;
      repeat (10) @(negedge clk);
    end
    // Released line must not keep the last bit
    mosi = ~mosi;
  endtask
endmodule // prog_link_model

// ===== tb/serial_prog_chk.sv
`timescale 1ns/1ps
module serial_prog_chk #(
  parameter int FLASH_WAIT_CYCLES = 50,
  parameter int EEPROM_WAIT_CYCLES = 50,
  parameter int ERASE_CYCLES = 50,
  parameter int FUSE_CYCLES = 50
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic prog_enabled,
  input wire logic busy,
  input wire logic [serial_prog_pkg::LOCK_W-1:0] lock_bits,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high
);
  // Loose upper bound: the kind of write is not visible at the ports
  localparam int MAX_BUSY = FLASH_WAIT_CYCLES + EEPROM_WAIT_CYCLES + ERASE_CYCLES + FUSE_CYCLES;
  localparam int MIN_BUSY = (FUSE_CYCLES < FLASH_WAIT_CYCLES) ? FUSE_CYCLES : FLASH_WAIT_CYCLES;
  logic [23:0] busy_len;
  always_ff @(posedge clk) begin
    busy_len <= (srst || !busy) ? 24'h0 : busy_len + 24'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_reset_values: assert property ($fell(srst) |-> !busy && !prog_enabled && !miso_oe
    && lock_bits == 6'h3f) else $error("reset values wrong");
  a_oe_pin_high: assert property (prog_reset_n [*7] |-> !miso_oe)
    else $error("miso driven outside session");
  a_enable_cleared: assert property (prog_reset_n [*7] |-> !prog_enabled)
    else $error("enable kept after reset pin high");
  a_enable_in_session: assert property ($rose(prog_enabled) |-> miso_oe)
    else $error("enable outside session");
  a_busy_needs_enable: assert property ($rose(busy) |-> prog_enabled)
    else $error("write taken before enable");
  a_lock_with_busy: assert property (!$stable(lock_bits) |-> ##[0:2] busy)
    else $error("lock change without write cycle");
  a_fuse_with_busy: assert property (!$stable({fuse_low, fuse_high}) |-> ##[0:2] busy)
    else $error("fuse change without write cycle");
  a_busy_max_len: assert property (busy_len <= MAX_BUSY)
    else $error("busy too long");
  a_busy_min_len: assert property ($fell(busy) |-> $past(busy_len) >= MIN_BUSY - 2)
    else $error("busy too short");
  a_miso_holds_high: assert property ((!prog_reset_n && sck) [*8] |-> $stable(miso))
    else $error("miso moved while clock high");
  c_enabled: cover property ($rose(prog_enabled));
  c_write_done: cover property ($fell(busy));
  c_session_end: cover property (prog_enabled ##1 !prog_enabled);
endmodule // serial_prog_chk

bind serial_program_command_unit serial_prog_chk #(.FLASH_WAIT_CYCLES(FLASH_WAIT_CYCLES),
  .EEPROM_WAIT_CYCLES(EEPROM_WAIT_CYCLES), .ERASE_CYCLES(ERASE_CYCLES),
  .FUSE_CYCLES(FUSE_CYCLES)) u_chk (.clk(clk), .srst(srst), .prog_reset_n(prog_reset_n),
  .sck(sck), .miso(miso), .miso_oe(miso_oe), .prog_enabled(prog_enabled), .busy(busy),
  .lock_bits(lock_bits), .fuse_low(fuse_low), .fuse_high(fuse_high));

// ===== tb/serial_program_command_unit_test.sv
`timescale 1ns/1ps
module serial_program_command_unit_test;
  import serial_prog_pkg::*;
  logic clk, srst, prog_reset_n, sck, mosi, miso, miso_oe, prog_enabled, busy;
  logic [31:0] cal_bytes;
  logic [LOCK_W-1:0] lock_bits;
  logic [7:0] fuse_low, fuse_high, ans, echo;
  int errors, total_checks;
  // EEPROM busy outlasts two frames so polling reads land inside it
  serial_program_command_unit #(.FLASH_WAIT_CYCLES(2000), .EEPROM_WAIT_CYCLES(3000),
    .ERASE_CYCLES(1000), .FUSE_CYCLES(300)) DUT (.clk(clk), .srst(srst),
    .prog_reset_n(prog_reset_n), .sck(sck), .mosi(mosi), .cal_bytes(cal_bytes), .miso(miso),
    .miso_oe(miso_oe), .prog_enabled(prog_enabled), .busy(busy), .lock_bits(lock_bits),
    .fuse_low(fuse_low), .fuse_high(fuse_high));
  prog_link_model link (.clk(clk), .miso(miso), .sck(sck), .mosi(mosi));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [31:0] c);
    logic [31:0] rx;
    link.xfer(c, rx);
    ans = rx[7:0];
    echo = rx[15:8];
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, busy}, 8'h00);
  endtask
  task automatic t_enable();
    cmd(32'hc0001077);
    chk({7'h0, busy}, 8'h00);
    cmd(32'hac530000);
    chk(echo, 8'h53);
    chk({6'h0, miso_oe, prog_enabled}, 8'h03);
  endtask
  task automatic t_erase();
    cmd(32'hac9f0000);
    chk({7'h0, busy}, 8'h01);
    wait_idle();
    chk({2'h0, lock_bits}, 8'h3f);
    cmd(32'ha0012300);
    chk(ans, 8'hff);
    cmd(32'h20014500);
    chk(ans, 8'hff);
  endtask
  task automatic t_fuse();
    cmd(32'haca0005a);
    wait_idle();
    chk(fuse_low, 8'h5a);
    cmd(32'haca8003c);
    wait_idle();
    chk(fuse_high, 8'h3c);
    cmd(32'h50000000);
    chk(ans, 8'h5a);
    cmd(32'h58080000);
    chk(ans, 8'h3c);
  endtask
  task automatic t_lock();
    cmd(32'hace500ea);
    wait_idle();
    chk({2'h0, lock_bits}, 8'h2a);
    cmd(32'h58000000);
    chk(ans, 8'hea);
  endtask
  task automatic t_eeprom();
    cmd(32'hc00123a5);
    cmd(32'hc0020011);
    cmd(32'ha0012300);
    chk(ans, 8'hff);
    wait_idle();
    cmd(32'ha03d2300);
    chk(ans, 8'ha5);
    cmd(32'ha0020000);
    chk(ans, 8'hff);
  endtask
  task automatic t_flash();
    cmd(32'h4000c511);
    cmd(32'h48000522);
    cmd(32'h4c017f00);
    chk({7'h0, busy}, 8'h01);
    cmd(32'h20014000);
    chk(ans, 8'hff);
    wait_idle();
    cmd(32'h20014500);
    chk(ans, 8'h11);
    cmd(32'h28014500);
    chk(ans, 8'h22);
  endtask
  task automatic t_cal();
    cal_bytes = 32'h44332211;
    cmd(32'h387e0200);
    chk(ans, 8'h33);
    cmd(32'hffffffff);
    chk({7'h0, busy}, 8'h00);
    chk(fuse_low, 8'h5a);
  endtask
  task automatic t_leave();
    prog_reset_n = 1'b1;
    repeat (8) @(negedge clk);
    chk({6'h0, miso_oe, prog_enabled}, 8'h00);
  endtask
  // Session dropped and reopened with SCK left high, as a resync retry does
  task automatic t_rejoin();
    t_leave();
    prog_reset_n = 1'b0;
    repeat (8) @(negedge clk);
    t_enable();
  endtask
  task automatic close_out();
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #480000;
    errors++;
    close_out();
  end
  initial begin
    srst = 1'b1;
    prog_reset_n = 1'b1;
    cal_bytes = 32'h0;
    errors = 0;
    total_checks = 0;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    prog_reset_n = 1'b0;
    repeat (8) @(negedge clk);
    t_enable();
    t_erase();
    t_fuse();
    t_lock();
    t_eeprom();
    t_flash();
    t_cal();
    t_rejoin();
    t_erase();
    t_leave();
    close_out();
  end
endmodule // serial_program_command_unit_test
